// >>> ccrb_checker.sv
`timescale 1ns/1ps
module ccrb_checker (
    input wire logic                       ref_clk_i,      // Clock
    input wire logic                       reset_i,        // Reset
    input wire logic [7:0]                 addr_i,         // Address
    input wire logic [31:0]                wdata_i,        // Write data
    input wire logic                       wr_i,           // Write strobe
    input wire logic                       rd_i,           // Read strobe
    input wire logic [31:0]                rdata_o,        // Read data
    input wire logic [1:0]                 group5_pins_i,  // Group 5 pins
    input wire ccrb_pkg::ccrb_prio_t       priority_o,     // Slots
    input wire logic [1:0]                 pin_group_four_mode_o, // G4
    input wire logic [1:0]                 pin_group_five_mode_o, // G5
    input wire ccrb_pkg::ccrb_swap_t       sd_card_byte_order_o,  // SD
    input wire logic                       mem_phy_main_reset_n_o, // Main
    input wire logic                       mem_phy_dll_reset_n_o,  // DLL
    input wire ccrb_pkg::ccrb_soft_reset_t soft_reset_o    // Resets
);
    logic [1:0]  rel_reg;
    logic [1:0]  rel_next;
    logic        bad;
    logic [14:0] pw;
    logic [2:0]  sdw;
    logic [8:0]  srw;
    logic        w_pr;
    logic        w_sr;

    ////////////////////////////////////////////////////////////////////////
    // Edges since reset release, saturating; strap flops need two
    always_comb begin
        rel_next = (rel_reg == 2'h3) ? rel_reg : rel_reg + 2'h1;
        if (reset_i) begin
            rel_next = 2'h0;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        rel_reg <= rel_next;
    end
    always_comb begin
        bad = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (wdata_i[4*i+:3] > 3'h4)
                bad = 1'b1;
            for (int j = 0; j < i; j++) begin
                if (wdata_i[4*i+:3] == wdata_i[4*j+:3])
                    bad = 1'b1;
            end
        end
    end
    assign pw = {wdata_i[18:16], wdata_i[14:12], wdata_i[10:8],
                 wdata_i[6:4], wdata_i[2:0]};
    assign sdw = {wdata_i[22], wdata_i[22] & ~wdata_i[21],
                  wdata_i[22] & ~wdata_i[20]};
    assign srw = {wdata_i[25:24], wdata_i[16], wdata_i[7], wdata_i[4:0]};
    assign w_pr = wr_i && addr_i == ccrb_pkg::PRIO_OFFSET;
    assign w_sr = wr_i && addr_i == ccrb_pkg::SOFTRST_OFFSET;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    property p_prio_keep;
        w_pr && bad |=> $stable(priority_o);
    endproperty
    a_prio_keep: assert property (p_prio_keep)
        else $error("bad priority write changed slots");
    property p_prio_take;
        w_pr && !bad |=> priority_o == $past(pw);
    endproperty
    a_prio_take: assert property (p_prio_take)
        else $error("good priority write not stored");
    property p_mux_wr;
        wr_i && addr_i == ccrb_pkg::PINMUX_OFFSET
            |=> pin_group_four_mode_o == $past(wdata_i[5:4]);
    endproperty
    a_mux_wr: assert property (p_mux_wr)
        else $error("group four mode not stored");
    property p_mux_rsvd;
        rd_i && addr_i == ccrb_pkg::PINMUX_OFFSET
            |=> rdata_o[31:6] == 26'h0 && !rdata_o[3];
    endproperty
    a_mux_rsvd: assert property (p_mux_rsvd)
        else $error("reserved mux bits read nonzero");
    property p_strap5;
        rel_reg >= 2'h2 |-> pin_group_five_mode_o ==
            ($past(group5_pins_i, 2) == 2'h3 ? 2'h0 : $past(group5_pins_i, 2));
    endproperty
    a_strap5: assert property (p_strap5)
        else $error("group five mode decode wrong");
    property p_order_sd;
        wr_i && addr_i == ccrb_pkg::BORDER_OFFSET
            |=> sd_card_byte_order_o == $past(sdw);
    endproperty
    a_order_sd: assert property (p_order_sd)
        else $error("sd byte order wrong");
    property p_phy_wr;
        wr_i && addr_i == ccrb_pkg::PHYRST_OFFSET |=>
            {mem_phy_main_reset_n_o, mem_phy_dll_reset_n_o} ==
                $past(wdata_i[1:0]);
    endproperty
    a_phy_wr: assert property (p_phy_wr)
        else $error("memory phy resets not following write");
    property p_sr_wr;
        w_sr |=> soft_reset_o == $past(srw);
    endproperty
    a_sr_wr: assert property (p_sr_wr)
        else $error("soft resets not following write");
    property p_sr_hold;
        !w_sr |=> $stable(soft_reset_o);
    endproperty
    a_sr_hold: assert property (p_sr_hold)
        else $error("soft resets changed without write");
endmodule

// >>> ccrb_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Slot codes: 000 capture/display, 001 AHB, 011 host bus, 100 draw.
// - Reset: second slot holds AHB code, first slot capture/display code.
// - Reserved write-ignored bits discard writes and read as zero.
// - Group 4 mode field bits 5-4: 00 mode0, 01 mode1, resets to 11.
// - Group 2 mode field bits 2-0: modes 0-4, resets to 111.
// - Strap status is read-only; bits 11-8 show PLL multiplier pins.
// - Bits 3-2 show group 5 pins; 11 decodes as mode 0.
// - Bits 1-0 show group 1 pins; 11 decodes as mode 0.
// - Endian top bit selects big; in big, zero swap bits enable swaps.
// - Endian fields at 22-20, 18-16, 14-12, 10-8; all reset zero.
// - Memory PHY reset bits: bit1 main, bit0 DLL; 0 resets, initial 0.
// - Soft reset bits drive level resets following the stored bit.
// - Soft reset bit 25 UART1, bit 24 UART0, bit 16 DMA.
// - Soft reset bit 7 GPIO, bit 4 display 1, bit 3 display 0.
// - Soft reset bit 2 capture 1, bit 1 capture 0, bit 0 draw engine.
// - Arbiter priority follows slot order, slot 0 highest.
// - Priority writes with codes of 5 or more or duplicates are ignored.
//////////////////////////////////////////////////////////////////////////////
package ccrb_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_SLOTS = 5;

    // Register byte offsets
    localparam logic [7:0] PRIO_OFFSET    = 8'h2c;
    localparam logic [7:0] PINMUX_OFFSET  = 8'h30;
    localparam logic [7:0] STRAP_OFFSET   = 8'h34;
    localparam logic [7:0] BORDER_OFFSET  = 8'he8;
    localparam logic [7:0] PHYRST_OFFSET  = 8'hec;
    localparam logic [7:0] SOFTRST_OFFSET = 8'hf0;

    // Master codes for the priority slots
    localparam logic [2:0] MASTER_CAPDISP = 3'h0;
    localparam logic [2:0] MASTER_AHB     = 3'h1;
    localparam logic [2:0] MASTER_FIXED   = 3'h2;
    localparam logic [2:0] MASTER_HOST    = 3'h3;
    localparam logic [2:0] MASTER_DRAW    = 3'h4;
    localparam logic [2:0] MASTER_LIMIT   = 3'h5;

    // Priority slot field positions (lsb), slot n at bit 4*n
    localparam int unsigned SLOT_STRIDE = 4;

    // Pin mux fields
    localparam int unsigned G4_LSB = 4;
    localparam int unsigned G2_LSB = 0;
    localparam logic [1:0] G4_RESET = 2'h3;
    localparam logic [2:0] G2_RESET = 3'h7;

    // Strap status fields
    localparam int unsigned PLL_LSB = 8;
    localparam int unsigned G5_LSB  = 2;
    localparam int unsigned G1_LSB  = 0;

    // Byte order: stored bits (endian fields plus reserved keep-zero fields)
    localparam logic [31:0] BORDER_MASK  = 32'h7777_7773;
    localparam logic [31:0] BORDER_RESET = 32'h0000_0000;
    localparam int unsigned SD_LSB = 20;
    localparam int unsigned A0_LSB = 16;
    localparam int unsigned A1_LSB = 12;
    localparam int unsigned A2_LSB = 8;

    // Memory PHY reset bits
    localparam int unsigned PHY_MAIN_BIT = 1;
    localparam int unsigned PHY_DLL_BIT  = 0;
    localparam logic [1:0]  PHYRST_RESET = 2'h0;

    // Soft reset register 0
    localparam logic [31:0] SOFTRST_MASK  = 32'h0301_009f;
    localparam logic [31:0] SOFTRST_RESET = 32'h0000_0000;
    localparam int unsigned SR_UART1   = 25;
    localparam int unsigned SR_UART0   = 24;
    localparam int unsigned SR_DMA     = 16;
    localparam int unsigned SR_GPIO    = 7;
    localparam int unsigned SR_DISP1   = 4;
    localparam int unsigned SR_DISP0   = 3;
    localparam int unsigned SR_CAP1    = 2;
    localparam int unsigned SR_CAP0    = 1;
    localparam int unsigned SR_DRAW    = 0;

    typedef logic [2:0] ccrb_code_t;

    typedef struct packed {
        ccrb_code_t slot4;
        ccrb_code_t slot3;
        ccrb_code_t slot2;
        ccrb_code_t slot1;
        ccrb_code_t slot0;
    } ccrb_prio_t;

    localparam ccrb_prio_t PRIO_RESET = '{
        slot4: MASTER_DRAW, slot3: MASTER_HOST, slot2: MASTER_FIXED,
        slot1: MASTER_AHB, slot0: MASTER_CAPDISP};

    typedef struct packed {
        logic big_endian;
        logic halfword_swap_en;
        logic word_swap_en;
    } ccrb_swap_t;

    typedef struct packed {
        logic uart1;
        logic uart0;
        logic dma;
        logic gpio;
        logic display1;
        logic display0;
        logic capture1;
        logic capture0;
        logic draw_engine;
    } ccrb_soft_reset_t;

endpackage

// >>> ccrb_register_bank.sv
`timescale 1ns/1ps
module ccrb_register_bank (
    input  wire logic                        ref_clk_i,        // Bus clock
    input  wire logic                        reset_i,          // Sync reset
    input  wire logic [ccrb_pkg::ADDR_W-1:0] addr_i,           // Byte address
    input  wire logic [ccrb_pkg::DATA_W-1:0] wdata_i,          // Write data
    input  wire logic                        wr_i,             // Write strobe
    input  wire logic                        rd_i,             // Read strobe
    output logic      [ccrb_pkg::DATA_W-1:0] rdata_o,          // Read data
    input  wire logic [3:0]                  pll_strap_pins_i, // PLL pins
    input  wire logic [1:0]                  group5_pins_i,    // Group 5 pins
    input  wire logic [1:0]                  group1_pins_i,    // Group 1 pins
    output ccrb_pkg::ccrb_prio_t             priority_o,       // Slot codes
    output logic [1:0]                       pin_group_four_mode_o, // G4
    output logic [2:0]                       pin_group_two_mode_o,  // G2
    output logic [1:0]                       pin_group_five_mode_o, // G5 dec
    output logic [1:0]                       pin_group_one_mode_o,  // G1 dec
    output ccrb_pkg::ccrb_swap_t             sd_card_byte_order_o,  // SD
    output ccrb_pkg::ccrb_swap_t             audio_port0_byte_order_o, // A0
    output ccrb_pkg::ccrb_swap_t             audio_port1_byte_order_o, // A1
    output ccrb_pkg::ccrb_swap_t             audio_port2_byte_order_o, // A2
    output logic                             mem_phy_main_reset_n_o, // Main
    output logic                             mem_phy_dll_reset_n_o,  // DLL
    output ccrb_pkg::ccrb_soft_reset_t       soft_reset_o      // Macro resets
);

    //////////////////////////////////////////////////////////////////////////
    // Strap synchroniser

    logic [7:0] strap_meta_reg;
    logic [7:0] strap_meta_next;
    logic [7:0] strap_sync_reg;
    logic [7:0] strap_sync_next;

    always_comb begin
        strap_meta_next = {pll_strap_pins_i, group5_pins_i,
                           group1_pins_i};
        strap_sync_next = strap_meta_reg;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            strap_meta_reg <= 8'h00;
            strap_sync_reg <= 8'h00;
        end else begin
            strap_meta_reg <= strap_meta_next;
            strap_sync_reg <= strap_sync_next;
        end
    end

    logic [3:0] pll_sync;
    logic [1:0] g5_sync;
    logic [1:0] g1_sync;

    assign pll_sync = strap_sync_reg[7:4];
    assign g5_sync  = strap_sync_reg[3:2];
    assign g1_sync  = strap_sync_reg[1:0];

    //////////////////////////////////////////////////////////////////////////
    // Address decode

    logic sel_prio;
    logic sel_pinmux;
    logic sel_strap;
    logic sel_border;
    logic sel_phyrst;
    logic sel_softrst;

    always_comb begin
        sel_prio    = 1'b0;
        sel_pinmux  = 1'b0;
        sel_strap   = 1'b0;
        sel_border  = 1'b0;
        sel_phyrst  = 1'b0;
        sel_softrst = 1'b0;
        if (addr_i == ccrb_pkg::PRIO_OFFSET) begin
            sel_prio = 1'b1;
        end else if (addr_i == ccrb_pkg::PINMUX_OFFSET) begin
            sel_pinmux = 1'b1;
        end else if (addr_i == ccrb_pkg::STRAP_OFFSET) begin
            sel_strap = 1'b1;
        end else if (addr_i == ccrb_pkg::BORDER_OFFSET) begin
            sel_border = 1'b1;
        end else if (addr_i == ccrb_pkg::PHYRST_OFFSET) begin
            sel_phyrst = 1'b1;
        end else if (addr_i == ccrb_pkg::SOFTRST_OFFSET) begin
            sel_softrst = 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Priority write check

    ccrb_pkg::ccrb_code_t wr_code [ccrb_pkg::NUM_SLOTS];
    logic                 prio_ok;

    always_comb begin
        prio_ok = 1'b1;
        for (int i = 0; i < ccrb_pkg::NUM_SLOTS; i++) begin
            wr_code[i] = wdata_i[i*ccrb_pkg::SLOT_STRIDE +: 3];
        end
        for (int i = 0; i < ccrb_pkg::NUM_SLOTS; i++) begin
            if (wr_code[i] >= ccrb_pkg::MASTER_LIMIT) begin
                prio_ok = 1'b0;
            end
            for (int j = i + 1; j < ccrb_pkg::NUM_SLOTS; j++) begin
                if (wr_code[i] == wr_code[j]) begin
                    prio_ok = 1'b0;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Register state

    ccrb_pkg::ccrb_prio_t prio_reg;
    ccrb_pkg::ccrb_prio_t prio_next;
    logic [1:0]           g4_reg;
    logic [1:0]           g4_next;
    logic [2:0]           g2_reg;
    logic [2:0]           g2_next;
    logic [31:0]          border_reg;
    logic [31:0]          border_next;
    logic [1:0]           phyrst_reg;
    logic [1:0]           phyrst_next;
    logic [31:0]          softrst_reg;
    logic [31:0]          softrst_next;

    always_comb begin
        prio_next    = prio_reg;
        g4_next      = g4_reg;
        g2_next      = g2_reg;
        border_next  = border_reg;
        phyrst_next  = phyrst_reg;
        softrst_next = softrst_reg;
        if (wr_i) begin
            if (sel_prio && prio_ok) begin
                prio_next = '{slot4: wr_code[4], slot3: wr_code[3],
                              slot2: wr_code[2], slot1: wr_code[1],
                              slot0: wr_code[0]};
            end
            if (sel_pinmux) begin
                g4_next = wdata_i[ccrb_pkg::G4_LSB +: 2];
                g2_next = wdata_i[ccrb_pkg::G2_LSB +: 3];
            end
            if (sel_border) begin
                border_next = wdata_i & ccrb_pkg::BORDER_MASK;
            end
            if (sel_phyrst) begin
                phyrst_next = {wdata_i[ccrb_pkg::PHY_MAIN_BIT],
                               wdata_i[ccrb_pkg::PHY_DLL_BIT]};
            end
            if (sel_softrst) begin
                softrst_next = wdata_i &
                               ccrb_pkg::SOFTRST_MASK;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            prio_reg    <= ccrb_pkg::PRIO_RESET;
            g4_reg      <= ccrb_pkg::G4_RESET;
            g2_reg      <= ccrb_pkg::G2_RESET;
            border_reg  <= ccrb_pkg::BORDER_RESET;
            phyrst_reg  <= ccrb_pkg::PHYRST_RESET;
            softrst_reg <= ccrb_pkg::SOFTRST_RESET;
        end else begin
            prio_reg    <= prio_next;
            g4_reg      <= g4_next;
            g2_reg      <= g2_next;
            border_reg  <= border_next;
            phyrst_reg  <= phyrst_next;
            softrst_reg <= softrst_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read path

    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (rd_i) begin
            if (sel_prio) begin
                rdata_next = {13'h0000, prio_reg.slot4, 1'b0, prio_reg.slot3,
                              1'b0, prio_reg.slot2, 1'b0, prio_reg.slot1,
                              1'b0, prio_reg.slot0};
            end else if (sel_pinmux) begin
                rdata_next[ccrb_pkg::G4_LSB +: 2] = g4_reg;
                rdata_next[ccrb_pkg::G2_LSB +: 3] = g2_reg;
            end else if (sel_strap) begin
                rdata_next[ccrb_pkg::PLL_LSB +: 4] = pll_sync;
                rdata_next[ccrb_pkg::G5_LSB +: 2]  = g5_sync;
                rdata_next[ccrb_pkg::G1_LSB +: 2]  = g1_sync;
            end else if (sel_border) begin
                rdata_next = border_reg;
            end else if (sel_phyrst) begin
                rdata_next[ccrb_pkg::PHY_MAIN_BIT] = phyrst_reg[1];
                rdata_next[ccrb_pkg::PHY_DLL_BIT]  = phyrst_reg[0];
            end else if (sel_softrst) begin
                rdata_next = softrst_reg;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;

    //////////////////////////////////////////////////////////////////////////
    // Control outputs

    function automatic logic [1:0] strap_mode(input logic [1:0] pins);
        strap_mode = (pins == 2'h3) ? 2'h0 : pins;
    endfunction

    function automatic ccrb_pkg::ccrb_swap_t swap_ctl(input logic [2:0] f);
        ccrb_pkg::ccrb_swap_t s;
        s.big_endian       = f[2];
        s.halfword_swap_en = f[2] & ~f[1];
        s.word_swap_en     = f[2] & ~f[0];
        swap_ctl = s;
    endfunction

    assign priority_o            = prio_reg;
    assign pin_group_four_mode_o = g4_reg;
    assign pin_group_two_mode_o  = g2_reg;
    assign pin_group_five_mode_o = strap_mode(g5_sync);
    assign pin_group_one_mode_o  = strap_mode(g1_sync);

    assign sd_card_byte_order_o =
        swap_ctl(border_reg[ccrb_pkg::SD_LSB +: 3]);
    assign audio_port0_byte_order_o =
        swap_ctl(border_reg[ccrb_pkg::A0_LSB +: 3]);
    assign audio_port1_byte_order_o =
        swap_ctl(border_reg[ccrb_pkg::A1_LSB +: 3]);
    assign audio_port2_byte_order_o =
        swap_ctl(border_reg[ccrb_pkg::A2_LSB +: 3]);

    assign mem_phy_main_reset_n_o = phyrst_reg[1];
    assign mem_phy_dll_reset_n_o  = phyrst_reg[0];

    assign soft_reset_o = '{
        uart1:       softrst_reg[ccrb_pkg::SR_UART1],
        uart0:       softrst_reg[ccrb_pkg::SR_UART0],
        dma:         softrst_reg[ccrb_pkg::SR_DMA],
        gpio:        softrst_reg[ccrb_pkg::SR_GPIO],
        display1:    softrst_reg[ccrb_pkg::SR_DISP1],
        display0:    softrst_reg[ccrb_pkg::SR_DISP0],
        capture1:    softrst_reg[ccrb_pkg::SR_CAP1],
        capture0:    softrst_reg[ccrb_pkg::SR_CAP0],
        draw_engine: softrst_reg[ccrb_pkg::SR_DRAW]
    };

endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
    logic                       ref_clk_i;
    logic                       reset_i;
    logic [7:0]                 addr_i;
    logic [31:0]                wdata_i;
    logic                       wr_i;
    logic                       rd_i;
    logic [31:0]                rdata_o;
    logic [3:0]                 pll_strap_pins_i;
    logic [1:0]                 group5_pins_i;
    logic [1:0]                 group1_pins_i;
    ccrb_pkg::ccrb_prio_t       priority_o;
    logic [1:0]                 m4;
    logic [2:0]                 m2;
    logic [1:0]                 m5;
    logic [1:0]                 m1;
    ccrb_pkg::ccrb_swap_t       bo [4];
    logic                       pm_n;
    logic                       pd_n;
    ccrb_pkg::ccrb_soft_reset_t sr;
    int                         fails;
    int                         checks;
    int                         n;
    logic [31:0]                d;
    logic [31:0]                sh [4];
    logic [14:0]                pm;
    logic [2:0]                 c [5];
    logic [7:0]                 adr [4];
    logic [31:0]                msk [4];

    ccrb_register_bank i_dut (.ref_clk_i, .reset_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .pll_strap_pins_i, .group5_pins_i,
        .group1_pins_i, .priority_o, .pin_group_four_mode_o(m4),
        .pin_group_two_mode_o(m2), .pin_group_five_mode_o(m5),
        .pin_group_one_mode_o(m1), .sd_card_byte_order_o(bo[0]),
        .audio_port0_byte_order_o(bo[1]), .audio_port1_byte_order_o(bo[2]),
        .audio_port2_byte_order_o(bo[3]), .mem_phy_main_reset_n_o(pm_n),
        .mem_phy_dll_reset_n_o(pd_n), .soft_reset_o(sr));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] sw(input logic [2:0] f);
        return {f[2], f[2] & ~f[1], f[2] & ~f[0]};
    endfunction
    function automatic logic [1:0] dec(input logic [1:0] p);
        return (p == 2'h3) ? 2'h0 : p;
    endfunction
    function automatic logic ok(input logic [31:0] v);
        ok = 1'b1;
        for (int i = 0; i < 5; i++) begin
            if (v[4*i+:3] > 3'h4)
                ok = 1'b0;
            for (int j = 0; j < i; j++) begin
                if (v[4*i+:3] == v[4*j+:3])
                    ok = 1'b0;
            end
        end
    endfunction
    function automatic logic [31:0] pr(input logic [14:0] p);
        return {13'h0, p[14:12], 1'b0, p[11:9], 1'b0, p[8:6], 1'b0,
                p[5:3], 1'b0, p[2:0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask
    task automatic ports();
        chk({17'h0, priority_o}, {17'h0, pm});
        chk({27'h0, m4, m2}, {27'h0, sh[0][5:4], sh[0][2:0]});
        chk({20'h0, bo[0], bo[1], bo[2], bo[3]},
            {20'h0, sw(sh[1][22:20]), sw(sh[1][18:16]), sw(sh[1][14:12]),
            sw(sh[1][10:8])});
        chk({30'h0, pm_n, pd_n}, {30'h0, sh[2][1:0]});
        chk({23'h0, sr}, {23'h0, sh[3][25:24], sh[3][16], sh[3][7],
            sh[3][4:0]});
    endtask
    task automatic reset_check();
        sh = '{32'h37, 32'h0, 32'h0, 32'h0};
        pm = {3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
        rd(ccrb_pkg::PRIO_OFFSET, 32'h0004_3210);
        for (int i = 0; i < 4; i++)
            rd(adr[i], sh[i]);
        ports();
    endtask
    task automatic results();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        reset_i = 1'b1;
        {addr_i, wdata_i, wr_i, rd_i} = '0;
        {pll_strap_pins_i, group5_pins_i, group1_pins_i} = '0;
        fails = 0;
        checks = 0;
        adr = '{ccrb_pkg::PINMUX_OFFSET, ccrb_pkg::BORDER_OFFSET,
                ccrb_pkg::PHYRST_OFFSET, ccrb_pkg::SOFTRST_OFFSET};
        msk = '{32'h37, ccrb_pkg::BORDER_MASK, 32'h3, ccrb_pkg::SOFTRST_MASK};
        void'($urandom(32'hf152));
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        reset_check();
        for (n = 0; n < 48; n++) begin
            d = (n < 4) ? 32'hffff_ffff : $urandom;
            if (n % 4 == 1) begin
                d = d & ~32'h7700_0073;
            end
            wr(adr[n % 4], d);
            sh[n % 4] = d & msk[n % 4];
            rd(adr[n % 4], sh[n % 4]);
            ports();
        end
        for (n = 0; n < 32; n++) begin
            c = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
            c[0] = c[$urandom_range(1) * 3];
            c[3 + $urandom_range(1)] = 3'(n % 4);
            if (n % 3 == 1)
                c[$urandom_range(1)] = 3'($urandom_range(7));
            c[$urandom_range(1) == 0 ? 4 : 1] = 3'h4 - 3'(n % 2);
            d = ($urandom & ~32'h0007_7777) | {13'h0, c[4], 1'b0, c[3],
                1'b0, c[2], 1'b0, c[1], 1'b0, c[0]};
            wr(ccrb_pkg::PRIO_OFFSET, d);
            if (ok(d))
                pm = {d[18:16], d[14:12], d[10:8], d[6:4], d[2:0]};
            rd(ccrb_pkg::PRIO_OFFSET, pr(pm));
            ports();
        end
        for (n = 0; n < 8; n++) begin
            @(posedge ref_clk_i);
            pll_strap_pins_i <= 4'($urandom);
            group5_pins_i <= 2'(n);
            group1_pins_i <= 2'h3 - 2'(n);
            repeat (3) @(posedge ref_clk_i);
            #1;
            chk({28'h0, m5, m1}, {28'h0, dec(group5_pins_i),
                dec(group1_pins_i)});
            rd(ccrb_pkg::STRAP_OFFSET, {20'h0, pll_strap_pins_i, 4'h0,
                group5_pins_i, group1_pins_i});
        end
        wr(ccrb_pkg::STRAP_OFFSET, 32'hffff_ffff);
        rd(ccrb_pkg::STRAP_OFFSET, {20'h0, pll_strap_pins_i, 4'h0,
            group5_pins_i, group1_pins_i});
        wr(8'h40, $urandom);
        rd(8'h40, 32'h0);
        ports();
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        reset_check();
        results();
    end

endmodule

bind ccrb_register_bank ccrb_checker i_chk (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .group5_pins_i(group5_pins_i),
    .priority_o(priority_o),
    .pin_group_four_mode_o(pin_group_four_mode_o),
    .pin_group_five_mode_o(pin_group_five_mode_o),
    .sd_card_byte_order_o(sd_card_byte_order_o),
    .mem_phy_main_reset_n_o(mem_phy_main_reset_n_o),
    .mem_phy_dll_reset_n_o(mem_phy_dll_reset_n_o),
    .soft_reset_o(soft_reset_o));
